// *** hw/fault_summary_mask_logic.sv ***
// Fault summary mask registers with AXI4-Lite access and interrupt
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "fsml_defs.svh"
module fault_summary_mask_logic
  import fsml_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // AXI4-Lite write address
  input wire logic [11:0] s_awaddr,
  input wire logic [2:0] s_awprot,
  input wire logic s_awvalid,
  output logic s_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // AXI4-Lite write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_araddr,
  input wire logic [2:0] s_arprot,
  input wire logic s_arvalid,
  output logic s_arready,
  // AXI4-Lite read data
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Supply fault flags, active low
  input wire logic ana_supply_over_volt_flag_n,
  input wire logic ana_supply_under_volt_flag_n,
  input wire logic io_supply_over_volt_flag_n,
  input wire logic io_supply_under_volt_flag_n,
  input wire logic dig_supply_over_volt_flag_n,
  input wire logic dig_supply_under_volt_flag_n,
  input wire logic ana_supply_oscillation_flag_n,
  input wire logic io_supply_oscillation_flag_n,
  input wire logic dig_supply_oscillation_flag_n,
  input wire logic ana_reg_overtemp_warn_flag_n,
  input wire logic io_reg_overtemp_warn_flag_n,
  input wire logic ana_reg_current_limit_flag_n,
  input wire logic io_reg_current_limit_flag_n,
  input wire logic ana_ground_a_disconnect_flag_n,
  input wire logic ana_ground_b_disconnect_flag_n,
  input wire logic dig_ground_disconnect_flag_n,
  // Clock fault flags, active low
  input wire logic main_clk_freq_range_flag_n,
  input wire logic diag_osc_watchdog_flag_n,
  input wire logic main_clk_watchdog_flag_n,
  // Summary flags and interrupt
  output logic supply_summary_fault_n,
  output logic clock_summary_fault_n,
  output logic irq
);

  // ==================================================
  // Declarations
  fsml_word16_t supply_fault_mask_reg;
  fsml_word16_t supply_fault_mask_next;
  fsml_word16_t clock_fault_mask_reg;
  fsml_word16_t clock_fault_mask_next;
  fsml_irq_t irq_status_reg;
  fsml_irq_t irq_status_next;
  fsml_irq_t irq_mask_reg;
  fsml_irq_t irq_mask_next;
  fsml_irq_t irq_set;
  fsml_irq_t irq_clr;
  logic supply_prev_reg;
  logic clock_prev_reg;
  fsml_word16_t sup_flags_n;
  logic [2:0] clk_flags_n;
  fsml_word16_t strobe_mask;
  logic aw_held_reg;
  logic w_held_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_fire;
  logic w_fire;
  logic do_write;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  fsml_index_t wr_idx;
  fsml_index_t rd_idx;
  logic bvalid_reg;
  fsml_resp_t bresp_reg;
  logic rvalid_reg;
  fsml_resp_t rresp_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_word;
  fsml_resp_t rd_resp;
  logic ar_fire;

  fsml_mask_if #(.WIDTH(16)) sup_bus ();
  fsml_mask_if #(.WIDTH(3)) clk_bus ();

  // ==================================================
  // Source flag vectors, positioned as their mask bits
  assign sup_flags_n[`FSML_ANA_SUPPLY_OVER_VOLT_MASK] =
    ana_supply_over_volt_flag_n;
  assign sup_flags_n[`FSML_ANA_SUPPLY_UNDER_VOLT_MASK] =
    ana_supply_under_volt_flag_n;
  assign sup_flags_n[`FSML_IO_SUPPLY_OVER_VOLT_MASK] =
    io_supply_over_volt_flag_n;
  assign sup_flags_n[`FSML_IO_SUPPLY_UNDER_VOLT_MASK] =
    io_supply_under_volt_flag_n;
  assign sup_flags_n[`FSML_DIG_SUPPLY_OVER_VOLT_MASK] =
    dig_supply_over_volt_flag_n;
  assign sup_flags_n[`FSML_DIG_SUPPLY_UNDER_VOLT_MASK] =
    dig_supply_under_volt_flag_n;
  assign sup_flags_n[`FSML_ANA_SUPPLY_OSCILLATION_MASK] =
    ana_supply_oscillation_flag_n;
  assign sup_flags_n[`FSML_IO_SUPPLY_OSCILLATION_MASK] =
    io_supply_oscillation_flag_n;
  assign sup_flags_n[`FSML_DIG_SUPPLY_OSCILLATION_MASK] =
    dig_supply_oscillation_flag_n;
  assign sup_flags_n[`FSML_ANA_REG_OVERTEMP_WARN_MASK] =
    ana_reg_overtemp_warn_flag_n;
  assign sup_flags_n[`FSML_IO_REG_OVERTEMP_WARN_MASK] =
    io_reg_overtemp_warn_flag_n;
  assign sup_flags_n[`FSML_ANA_REG_CURRENT_LIMIT_MASK] =
    ana_reg_current_limit_flag_n;
  assign sup_flags_n[`FSML_IO_REG_CURRENT_LIMIT_MASK] =
    io_reg_current_limit_flag_n;
  assign sup_flags_n[`FSML_ANA_GROUND_A_DISCONNECT_MASK] =
    ana_ground_a_disconnect_flag_n;
  assign sup_flags_n[`FSML_ANA_GROUND_B_DISCONNECT_MASK] =
    ana_ground_b_disconnect_flag_n;
  assign sup_flags_n[`FSML_DIG_GROUND_DISCONNECT_MASK] =
    dig_ground_disconnect_flag_n;
  assign clk_flags_n[`FSML_MAIN_CLK_FREQ_RANGE_MASK] =
    main_clk_freq_range_flag_n;
  assign clk_flags_n[`FSML_DIAG_OSC_WATCHDOG_MASK] =
    diag_osc_watchdog_flag_n;
  assign clk_flags_n[`FSML_MAIN_CLK_WATCHDOG_MASK] =
    main_clk_watchdog_flag_n;

  // ==================================================
  // Masked reduction into the two summaries
  assign sup_bus.flags_n = sup_flags_n;
  assign sup_bus.mask = supply_fault_mask_reg;
  assign clk_bus.flags_n = clk_flags_n;
  // Reserved clock mask bits never reach the reducer
  assign clk_bus.mask = clock_fault_mask_reg[2:0];

  fsml_mask_reduce u_supply_reduce (
    .clk(clk),
    .rst_b(rst_b),
    .bus(sup_bus.reducer)
  );

  fsml_mask_reduce u_clock_reduce (
    .clk(clk),
    .rst_b(rst_b),
    .bus(clk_bus.reducer)
  );

  assign supply_summary_fault_n = sup_bus.summary_n;
  assign clock_summary_fault_n = clk_bus.summary_n;

  // ==================================================
  // Write channel capture, either order
  assign s_awready = !aw_held_reg && !bvalid_reg;
  assign s_wready = !w_held_reg && !bvalid_reg;
  assign aw_fire = s_awvalid && s_awready;
  assign w_fire = s_wvalid && s_wready;
  assign wr_addr = aw_held_reg ? awaddr_reg : s_awaddr;
  assign wr_data = w_held_reg ? wdata_reg : s_wdata;
  assign wr_strb = w_held_reg ? wstrb_reg : s_wstrb;
  assign do_write = (aw_held_reg || aw_fire) && (w_held_reg || w_fire);
  assign wr_idx = wr_addr[11:2];
  assign strobe_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 12'h000;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end else if (aw_fire) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_awaddr;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      w_held_reg <= 1'b0;
      wdata_reg <= `FSML_DATA_ZERO;
      wstrb_reg <= 4'h0;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end else if (w_fire) begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_wdata;
      wstrb_reg <= s_wstrb;
    end
  end

  // ==================================================
  // Write response
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `FSML_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      unique case (wr_idx)
        `FSML_IDX_SUPPLY_MASK,
        `FSML_IDX_CLOCK_MASK,
        `FSML_IDX_IRQ_STATUS,
        `FSML_IDX_IRQ_MASK,
        `FSML_IDX_SUPPLY_FLAGS,
        `FSML_IDX_CLOCK_FLAGS: bresp_reg <= `FSML_RESP_OKAY;
        default: bresp_reg <= `FSML_RESP_SLVERR;
      endcase
    end else if (s_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_bvalid = bvalid_reg;
  assign s_bresp = bresp_reg;

  // ==================================================
  // Mask registers
  always_comb begin
    supply_fault_mask_next = supply_fault_mask_reg;
    if (do_write && wr_idx == `FSML_IDX_SUPPLY_MASK) begin
      supply_fault_mask_next = (supply_fault_mask_reg & ~strobe_mask) |
        (wr_data[15:0] & strobe_mask);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      supply_fault_mask_reg <= `FSML_MASK_RESET;
    end else begin
      supply_fault_mask_reg <= supply_fault_mask_next;
    end
  end

  // Bits 15:10 are stored as written; software keeps them zero
  always_comb begin
    clock_fault_mask_next = clock_fault_mask_reg;
    if (do_write && wr_idx == `FSML_IDX_CLOCK_MASK) begin
      clock_fault_mask_next = ((clock_fault_mask_reg & ~strobe_mask) |
        (wr_data[15:0] & strobe_mask)) & `FSML_CLOCK_MASK_WRITABLE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clock_fault_mask_reg <= `FSML_MASK_RESET;
    end else begin
      clock_fault_mask_reg <= clock_fault_mask_next;
    end
  end

  // ==================================================
  // Interrupt: summary falling edge sets a sticky bit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      supply_prev_reg <= 1'b1;
      clock_prev_reg <= 1'b1;
    end else begin
      supply_prev_reg <= sup_bus.summary_n;
      clock_prev_reg <= clk_bus.summary_n;
    end
  end

  assign irq_set[`FSML_IRQ_SUPPLY] = supply_prev_reg && !sup_bus.summary_n;
  assign irq_set[`FSML_IRQ_CLOCK] = clock_prev_reg && !clk_bus.summary_n;
  assign irq_clr = (do_write && wr_idx == `FSML_IDX_IRQ_STATUS &&
    wr_strb[0]) ? wr_data[1:0] : `FSML_IRQ_RESET;

  // Set beats clear so an edge landing on a clear is kept
  assign irq_status_next = (irq_status_reg & ~irq_clr) | irq_set;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_status_reg <= `FSML_IRQ_RESET;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  assign irq_mask_next = (do_write && wr_idx == `FSML_IDX_IRQ_MASK &&
    wr_strb[0]) ? wr_data[1:0] : irq_mask_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask_reg <= `FSML_IRQ_RESET;
      irq <= 1'b0;
    end else begin
      irq_mask_reg <= irq_mask_next;
      irq <= |(irq_status_next & irq_mask_next);
    end
  end

  // ==================================================
  // Read channel
  assign s_arready = !rvalid_reg;
  assign ar_fire = s_arvalid && s_arready;
  assign rd_idx = s_araddr[11:2];

  always_comb begin
    rd_word = `FSML_DATA_ZERO;
    rd_resp = `FSML_RESP_OKAY;
    unique case (rd_idx)
      `FSML_IDX_SUPPLY_MASK: rd_word[15:0] = supply_fault_mask_reg;
      `FSML_IDX_CLOCK_MASK:
        rd_word[15:0] = clock_fault_mask_reg &
          `FSML_CLOCK_MASK_WRITABLE;
      `FSML_IDX_IRQ_STATUS: rd_word[1:0] = irq_status_reg;
      `FSML_IDX_IRQ_MASK: rd_word[1:0] = irq_mask_reg;
      // Raw flags read unmasked: masking never alters the sources
      `FSML_IDX_SUPPLY_FLAGS: rd_word[15:0] = sup_flags_n;
      `FSML_IDX_CLOCK_FLAGS:
        rd_word[4:0] = {clk_bus.summary_n, sup_bus.summary_n,
          clk_flags_n};
      default: rd_resp = `FSML_RESP_SLVERR;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= `FSML_RESP_OKAY;
      rdata_reg <= `FSML_DATA_ZERO;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_resp;
      rdata_reg <= rd_word;
    end else if (s_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_rvalid = rvalid_reg;
  assign s_rresp = rresp_reg;
  assign s_rdata = rdata_reg;

endmodule
`default_nettype wire

// *** hw/fsml_mask_reduce.sv ***
// Registered masked AND-reduction of active-low fault flags
`timescale 1ns/1ps
`default_nettype none
module fsml_mask_reduce
  import fsml_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Flags, mask and summary
  fsml_mask_if.reducer bus
);
  logic summary_reg;
  logic summary_next;

  // A set mask bit forces its flag to the idle (high) level
  assign summary_next = &(bus.flags_n | bus.mask);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      summary_reg <= 1'b1;
    end else begin
      summary_reg <= summary_next;
    end
  end

  assign bus.summary_n = summary_reg;
endmodule
`default_nettype wire

// *** inc/fsml_defs.svh ***
// Offsets, field positions, reset values and codes of the fault mask block
`ifndef FSML_DEFS_SVH
`define FSML_DEFS_SVH

// ==================================================
// Register indices (byte address is four times the index)
`define FSML_IDX_SUPPLY_MASK 10'h047
`define FSML_IDX_CLOCK_MASK 10'h048
`define FSML_IDX_IRQ_STATUS 10'h060
`define FSML_IDX_IRQ_MASK 10'h061
`define FSML_IDX_SUPPLY_FLAGS 10'h062
`define FSML_IDX_CLOCK_FLAGS 10'h063

// ==================================================
// Supply mask field positions
`define FSML_ANA_SUPPLY_OVER_VOLT_MASK 15
`define FSML_ANA_SUPPLY_UNDER_VOLT_MASK 14
`define FSML_IO_SUPPLY_OVER_VOLT_MASK 13
`define FSML_IO_SUPPLY_UNDER_VOLT_MASK 12
`define FSML_DIG_SUPPLY_OVER_VOLT_MASK 11
`define FSML_DIG_SUPPLY_UNDER_VOLT_MASK 10
`define FSML_ANA_SUPPLY_OSCILLATION_MASK 9
`define FSML_IO_SUPPLY_OSCILLATION_MASK 8
`define FSML_DIG_SUPPLY_OSCILLATION_MASK 7
`define FSML_ANA_REG_OVERTEMP_WARN_MASK 6
`define FSML_IO_REG_OVERTEMP_WARN_MASK 5
`define FSML_ANA_REG_CURRENT_LIMIT_MASK 4
`define FSML_IO_REG_CURRENT_LIMIT_MASK 3
`define FSML_ANA_GROUND_A_DISCONNECT_MASK 2
`define FSML_ANA_GROUND_B_DISCONNECT_MASK 1
`define FSML_DIG_GROUND_DISCONNECT_MASK 0

// ==================================================
// Clock mask field positions and writable bits
`define FSML_MAIN_CLK_FREQ_RANGE_MASK 2
`define FSML_DIAG_OSC_WATCHDOG_MASK 1
`define FSML_MAIN_CLK_WATCHDOG_MASK 0
`define FSML_CLOCK_MASK_WRITABLE 16'hfc07
`define FSML_CLOCK_MASK_ACTIVE 3'h7

// ==================================================
// Interrupt status bits
`define FSML_IRQ_SUPPLY 0
`define FSML_IRQ_CLOCK 1

// ==================================================
// Reset values and bus codes
`define FSML_MASK_RESET 16'h0000
`define FSML_IRQ_RESET 2'h0
`define FSML_RESP_OKAY 2'h0
`define FSML_RESP_SLVERR 2'h2
`define FSML_DATA_ZERO 32'h0000_0000

`endif

// *** inc/fsml_mask_if.sv ***
// Flag, mask and summary bundle between the top and a reducer
`timescale 1ns/1ps
`default_nettype none
interface fsml_mask_if #(parameter int WIDTH = 16);
  logic [WIDTH-1:0] flags_n;
  logic [WIDTH-1:0] mask;
  logic summary_n;
  modport reducer (input flags_n, input mask, output summary_n);
  modport owner (output flags_n, output mask, input summary_n);
endinterface
`default_nettype wire

// *** inc/fsml_pkg.sv ***
// Types shared by the fault mask block
package fsml_pkg;
  typedef logic [15:0] fsml_word16_t;
  typedef logic [1:0] fsml_resp_t;
  typedef logic [1:0] fsml_irq_t;
  typedef logic [9:0] fsml_index_t;
endpackage

// *** verif/fsml_fault_asserts.sv ***
// Port-level checks of the fault summary mask block
`timescale 1ns/1ps
`default_nettype none
`include "fsml_defs.svh"
module fsml_fault_asserts (
  // Clock, reset and bus handshakes
  input wire logic clk, rst_b, s_awvalid, s_awready, s_wvalid, s_wready,
  input wire logic s_bvalid, s_bready, s_arvalid, s_arready,
  input wire logic s_rvalid, s_rready, irq,
  input wire logic [11:0] s_awaddr, s_araddr,
  input wire logic [31:0] s_wdata, s_rdata,
  input wire logic [3:0] s_wstrb,
  input wire logic [1:0] s_bresp, s_rresp,
  // Fault flags and summaries
  input wire logic ana_supply_over_volt_flag_n, ana_supply_under_volt_flag_n,
  input wire logic io_supply_over_volt_flag_n, io_supply_under_volt_flag_n,
  input wire logic dig_supply_over_volt_flag_n, dig_supply_under_volt_flag_n,
  input wire logic ana_supply_oscillation_flag_n,
  input wire logic io_supply_oscillation_flag_n,
  input wire logic dig_supply_oscillation_flag_n,
  input wire logic ana_reg_overtemp_warn_flag_n, io_reg_overtemp_warn_flag_n,
  input wire logic ana_reg_current_limit_flag_n, io_reg_current_limit_flag_n,
  input wire logic ana_ground_a_disconnect_flag_n,
  input wire logic ana_ground_b_disconnect_flag_n,
  input wire logic dig_ground_disconnect_flag_n, main_clk_freq_range_flag_n,
  input wire logic diag_osc_watchdog_flag_n, main_clk_watchdog_flag_n,
  input wire logic supply_summary_fault_n, clock_summary_fault_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  localparam logic [11:0] A_SUP = {`FSML_IDX_SUPPLY_MASK, 2'h0};
  localparam logic [11:0] A_CLK = {`FSML_IDX_CLOCK_MASK, 2'h0};
  localparam logic [11:0] A_IST = {`FSML_IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] A_IMSK = {`FSML_IDX_IRQ_MASK, 2'h0};
  localparam logic [11:0] A_RSUP = {`FSML_IDX_SUPPLY_FLAGS, 2'h0};
  localparam logic [11:0] A_RCLK = {`FSML_IDX_CLOCK_FLAGS, 2'h0};
  // ==========================================================
  // Shadow of the mask registers, rebuilt from bus traffic
  logic [15:0] sup_f, sup_m, clk_m;
  logic [2:0] clk_f;
  logic [1:0] irq_m;
  logic aw_p, w_p, wr_go, rd_chk, rd_bad, exp_sup, exp_clk;
  logic [11:0] aw_a, wa;
  logic [31:0] w_d, wd, rd_exp;
  logic [3:0] w_s, ws;
  assign sup_f = {ana_supply_over_volt_flag_n, ana_supply_under_volt_flag_n,
    io_supply_over_volt_flag_n, io_supply_under_volt_flag_n,
    dig_supply_over_volt_flag_n, dig_supply_under_volt_flag_n,
    ana_supply_oscillation_flag_n, io_supply_oscillation_flag_n,
    dig_supply_oscillation_flag_n, ana_reg_overtemp_warn_flag_n,
    io_reg_overtemp_warn_flag_n, ana_reg_current_limit_flag_n,
    io_reg_current_limit_flag_n, ana_ground_a_disconnect_flag_n,
    ana_ground_b_disconnect_flag_n, dig_ground_disconnect_flag_n};
  assign clk_f = {main_clk_freq_range_flag_n, diag_osc_watchdog_flag_n,
    main_clk_watchdog_flag_n};
  assign exp_sup = &(sup_f | sup_m);
  assign exp_clk = &(clk_f | clk_m[2:0]);
  // Address and data may be taken on different edges
  assign wa = aw_p ? aw_a : s_awaddr;
  assign wd = w_p ? w_d : s_wdata;
  assign ws = w_p ? w_s : s_wstrb;
  assign wr_go = (aw_p || (s_awvalid && s_awready)) &&
    (w_p || (s_wvalid && s_wready));
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_p <= 1'h0;
      w_p <= 1'h0;
      aw_a <= 12'h000;
      w_d <= 32'h0000_0000;
      w_s <= 4'h0;
      sup_m <= 16'h0000;
      clk_m <= 16'h0000;
      irq_m <= 2'h0;
      rd_chk <= 1'h0;
      rd_bad <= 1'h0;
      rd_exp <= 32'h0000_0000;
    end else begin
      aw_p <= !wr_go && (aw_p || (s_awvalid && s_awready));
      w_p <= !wr_go && (w_p || (s_wvalid && s_wready));
      if (s_awvalid && s_awready) aw_a <= s_awaddr;
      if (s_wvalid && s_wready) begin
        w_d <= s_wdata;
        w_s <= s_wstrb;
      end
      if (wr_go && wa == A_SUP && ws[0]) sup_m[7:0] <= wd[7:0];
      if (wr_go && wa == A_SUP && ws[1]) sup_m[15:8] <= wd[15:8];
      if (wr_go && wa == A_CLK && ws[0]) clk_m[7:0] <= wd[7:0] & 8'h07;
      if (wr_go && wa == A_CLK && ws[1]) clk_m[15:8] <= wd[15:8] & 8'hfc;
      if (wr_go && wa == A_IMSK && ws[0]) irq_m <= wd[1:0];
      if (s_arvalid && s_arready) begin
        rd_chk <= s_araddr == A_SUP || s_araddr == A_CLK;
        rd_exp <= {16'h0000, (s_araddr == A_SUP) ? sup_m : clk_m};
        rd_bad <= !(s_araddr inside {A_SUP, A_CLK, A_IST, A_IMSK, A_RSUP,
          A_RCLK});
      end
    end
  end
  // ==========================================================
  // Properties
  property p_sup_sum;
    rst_b |=> supply_summary_fault_n == $past(exp_sup);
  endproperty
  a_sup_sum: assert property (p_sup_sum)
    else $error("supply summary disagrees with masked flags");
  property p_clk_sum;
    rst_b |=> clock_summary_fault_n == $past(exp_clk);
  endproperty
  a_clk_sum: assert property (p_clk_sum)
    else $error("clock summary disagrees with masked flags");
  property p_sup_idle;
    &sup_f |=> supply_summary_fault_n;
  endproperty
  a_sup_idle: assert property (p_sup_idle)
    else $error("supply summary low with no supply fault");
  property p_rd_mask;
    s_rvalid && rd_chk |-> s_rdata == rd_exp;
  endproperty
  a_rd_mask: assert property (p_rd_mask)
    else $error("mask readback differs from written value");
  property p_rd_bad;
    s_rvalid && rd_bad |-> s_rresp == `FSML_RESP_SLVERR && s_rdata == 32'h0;
  endproperty
  a_rd_bad: assert property (p_rd_bad)
    else $error("unmapped read not refused");
  property p_irq_set;
    $fell(supply_summary_fault_n) && irq_m[`FSML_IRQ_SUPPLY] |-> ##[1:2] irq;
  endproperty
  a_irq_set: assert property (p_irq_set)
    else $error("supply summary event did not raise interrupt");
  property p_irq_off;
    irq_m == 2'h0 && !wr_go |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt high while fully masked");
  property p_b_hold;
    s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped before taken");
  property p_r_hold;
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped before taken");
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the fault summary mask block
`timescale 1ns/1ps
`default_nettype none
`include "fsml_defs.svh"
module tb;
  import fsml_pkg::*;
  localparam logic [11:0] A_SUP = {`FSML_IDX_SUPPLY_MASK, 2'h0};
  localparam logic [11:0] A_CLK = {`FSML_IDX_CLOCK_MASK, 2'h0};
  localparam logic [11:0] A_IST = {`FSML_IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] A_IMSK = {`FSML_IDX_IRQ_MASK, 2'h0};
  localparam logic [11:0] A_RSUP = {`FSML_IDX_SUPPLY_FLAGS, 2'h0};
  localparam logic [11:0] A_RCLK = {`FSML_IDX_CLOCK_FLAGS, 2'h0};
  localparam fsml_resp_t OK = `FSML_RESP_OKAY;
  logic clk, rst_b, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
  logic s_bready, s_arvalid, s_arready, s_rvalid, s_rready, irq;
  logic sup_sum_n, clk_sum_n;
  logic [11:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0] s_wstrb;
  fsml_resp_t s_bresp, s_rresp;
  fsml_word16_t sup_f, b16;
  logic [2:0] clk_f, b3;
  int n_errors, tests_run, cycles;
  fault_summary_mask_logic fault_summary_mask_logic_inst (
    .clk(clk), .rst_b(rst_b),
    .s_awaddr(s_awaddr), .s_awprot(3'h0), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
    .s_arprot(3'h0), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .ana_supply_over_volt_flag_n(sup_f[15]),
    .ana_supply_under_volt_flag_n(sup_f[14]),
    .io_supply_over_volt_flag_n(sup_f[13]),
    .io_supply_under_volt_flag_n(sup_f[12]),
    .dig_supply_over_volt_flag_n(sup_f[11]),
    .dig_supply_under_volt_flag_n(sup_f[10]),
    .ana_supply_oscillation_flag_n(sup_f[9]),
    .io_supply_oscillation_flag_n(sup_f[8]),
    .dig_supply_oscillation_flag_n(sup_f[7]),
    .ana_reg_overtemp_warn_flag_n(sup_f[6]),
    .io_reg_overtemp_warn_flag_n(sup_f[5]),
    .ana_reg_current_limit_flag_n(sup_f[4]),
    .io_reg_current_limit_flag_n(sup_f[3]),
    .ana_ground_a_disconnect_flag_n(sup_f[2]),
    .ana_ground_b_disconnect_flag_n(sup_f[1]),
    .dig_ground_disconnect_flag_n(sup_f[0]),
    .main_clk_freq_range_flag_n(clk_f[2]),
    .diag_osc_watchdog_flag_n(clk_f[1]),
    .main_clk_watchdog_flag_n(clk_f[0]),
    .supply_summary_fault_n(sup_sum_n), .clock_summary_fault_n(clk_sum_n),
    .irq(irq)
  );
  // ==========================================================
  // Checking and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Ready is raised one cycle late so the response must stand
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] st, input fsml_resp_t er);
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= st;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && s_awready === 1'h1) begin
        aw_ok = 1'h1;
        s_awvalid <= 1'h0;
      end
      if (!w_ok && s_wready === 1'h1) begin
        w_ok = 1'h1;
        s_wvalid <= 1'h0;
      end
    end
    @(posedge clk);
    s_bready <= 1'h1;
    do @(posedge clk); while (s_bvalid !== 1'h1);
    s_bready <= 1'h0;
    check(32'(s_bresp), 32'(er));
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
    input fsml_resp_t er);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    do @(posedge clk); while (s_arready !== 1'h1);
    s_arvalid <= 1'h0;
    @(posedge clk);
    s_rready <= 1'h1;
    do @(posedge clk); while (s_rvalid !== 1'h1);
    s_rready <= 1'h0;
    check(s_rdata, ed);
    check(32'(s_rresp), 32'(er));
  endtask
  // ==========================================================
  // Clock and hang guard
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_errors++;
      end_of_test();
    end
  end
  // ==========================================================
  // Test sequence
  initial begin
    {rst_b, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 6'h00;
    {s_awaddr, s_araddr, s_wstrb} = 28'h0;
    s_wdata = 32'h0;
    sup_f = 16'hffff;
    clk_f = 3'h7;
    {n_errors, tests_run, cycles} = 96'h0;
    repeat (16) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    check(32'({sup_sum_n, clk_sum_n, irq}), 32'h6);
    rd(A_SUP, 32'h0, OK);
    rd(A_CLK, 32'h0, OK);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      b16 = 16'h0001 << i;
      sup_f <= ~b16;
      repeat (2) @(posedge clk);
      check(32'(sup_sum_n), 32'h0);
      rd(A_RSUP, {16'h0, ~b16}, OK);
      wr(A_SUP, {16'h0, b16}, 4'h3, OK);
      repeat (2) @(posedge clk);
      check(32'(sup_sum_n), 32'h1);
      wr(A_SUP, {16'h0, ~b16}, 4'h3, OK);
      repeat (2) @(posedge clk);
      check(32'(sup_sum_n), 32'h0);
      rd(A_SUP, {16'h0, ~b16}, OK);
      sup_f <= 16'hffff;
      wr(A_SUP, 32'h0, 4'h3, OK);
    end
    $display("test supply masks done");
    for (int i = 0; i < 3; i++) begin
      b3 = 3'h1 << i;
      clk_f <= ~b3;
      repeat (2) @(posedge clk);
      check(32'(clk_sum_n), 32'h0);
      rd(A_RCLK, {27'h0, 2'h1, ~b3}, OK);
      wr(A_CLK, {29'h0, b3}, 4'h3, OK);
      repeat (2) @(posedge clk);
      check(32'(clk_sum_n), 32'h1);
      rd(A_CLK, {29'h0, b3}, OK);
      clk_f <= 3'h7;
      wr(A_CLK, 32'h0, 4'h3, OK);
    end
    wr(A_CLK, 32'h0000_03ff, 4'hf, OK);
    rd(A_CLK, 32'h0000_0007, OK);
    wr(A_CLK, 32'h0, 4'hf, OK);
    wr(A_SUP, 32'h0000_ffff, 4'h1, OK);
    rd(A_SUP, 32'h0000_00ff, OK);
    wr(A_SUP, 32'h0, 4'h3, OK);
    $display("test clock masks done");
    wr(A_IMSK, 32'h1, 4'h1, OK);
    sup_f <= 16'hfffe;
    repeat (3) @(posedge clk);
    check(32'(irq), 32'h1);
    clk_f <= 3'h6;
    repeat (3) @(posedge clk);
    rd(A_IST, 32'h3, OK);
    wr(A_IMSK, 32'h0, 4'h1, OK);
    @(posedge clk);
    check(32'(irq), 32'h0);
    wr(A_IMSK, 32'h2, 4'h1, OK);
    @(posedge clk);
    check(32'(irq), 32'h1);
    rd(A_IMSK, 32'h2, OK);
    wr(A_IST, 32'h3, 4'h1, OK);
    @(posedge clk);
    check(32'(irq), 32'h0);
    rd(A_IST, 32'h0, OK);
    sup_f <= 16'hffff;
    clk_f <= 3'h7;
    wr(A_IMSK, 32'h0, 4'h1, OK);
    $display("test interrupt done");
    rd(12'h1fc, 32'h0, `FSML_RESP_SLVERR);
    wr(12'h1fc, 32'hffff_ffff, 4'hf, `FSML_RESP_SLVERR);
    wr(A_RSUP, 32'h0000_ffff, 4'hf, OK);
    rd(A_SUP, 32'h0, OK);
    $display("test unmapped done");
    end_of_test();
  end
endmodule
bind fault_summary_mask_logic fsml_fault_asserts fsml_fault_asserts_inst (.*);
`default_nettype wire
